// ==== bench/tb.sv ====
// Bench for the USB global control block and its firmware-side controller on a shared register
// port; the bench is the APB master and sets the USB line levels.
// Assumes a 100 ns pclk and the shortened suspend, wake-up and resume counts set below.
`timescale 1ns/1ns
`include "usbgc_consts.svh"
module tb;
    import usbgc_pkg::*;
    logic pclk;
    logic presetn;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic power_down;
    logic line_se0;
    logic bus_j;
    logic line_j;
    logic sof_pid_seen;
    logic usb_irq;
    logic core_reset;
    logic xcvr_enable;
    logic core_clk_enable;
    logic clk48_enable;
    logic vref_oe;
    logic resume_k_drive;
    logic pad_low_power;
    logic use_default_addr;
    int err_count;
    int check_count;
    int cyc = 0;
    usbgc_if sfr_bus ();

    // The bus shows K while the block sends its own resume, so J is lost then too.
    assign line_j = bus_j && !resume_k_drive;

    usbgc_dev #(.RST_CYC(27), .SUSP_CYC(20), .RWU_CYC(40), .RES_CYC(10), .CW(17)) u_usbgc_dev (
        .pclk, .presetn, .sfr(sfr_bus), .line_se0, .line_j, .sof_pid_seen, .usb_irq,
        .core_reset, .xcvr_enable, .core_clk_enable, .clk48_enable, .vref_oe,
        .resume_k_drive, .pad_low_power, .use_default_addr);
    usbgc_fw u_usbgc_fw (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .power_down, .sfr(sfr_bus));
    usbgc_asserts u_usbgc_asserts (.pclk, .presetn, .sfr_addr(sfr_bus.sfr_addr),
        .sfr_wr(sfr_bus.sfr_wr), .sfr_rd(sfr_bus.sfr_rd), .sfr_wdata(sfr_bus.sfr_wdata),
        .sfr_rdata(sfr_bus.sfr_rdata), .line_se0, .usb_irq, .core_reset, .xcvr_enable,
        .core_clk_enable, .clk48_enable, .vref_oe, .use_default_addr);

    // Free-running 10 MHz clock.
    initial
    begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    // Hang guard; the scenarios need a few thousand cycles at most.
    always @(posedge pclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            $display("[FAIL] %0t timeout", $time);
            err_count++;
            wrap_up();
        end
    end

    task automatic wrap_up();
        if (err_count == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        check_count++;
        if (got !== exp)
        begin
            $display("[FAIL] %0t %s: got %h expected %h", $time, m, got, exp);
            err_count++;
        end
    endtask

    // One APB transfer, entered just after an edge; it holds the request until pready.
    task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d,
        output logic [31:0] q);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        q = prdata;
        chk(32'(pslverr), 32'h0, "slave error");
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    // Issue a command and poll busy, since a command sent while busy is dropped.
    task automatic fw_cmd(input logic [31:0] cmd);
        logic [31:0] q;
        apb(1'b1, `USBGC_APB_CMD, cmd, q);
        q = 32'h0000_0001;
        while (q[0] === 1'b1)
            apb(1'b0, `USBGC_APB_STAT, 32'h0000_0000, q);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        fw_cmd(32'h0001_0000 | {16'h0000, d, a});
    endtask

    task automatic rdq(input logic [7:0] a, output logic [7:0] v);
        logic [31:0] q;
        fw_cmd(32'h0002_0000 | {24'h00_0000, a});
        apb(1'b0, `USBGC_APB_STAT, 32'h0000_0000, q);
        v = q[15:8];
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [7:0] e, input string m);
        logic [7:0] v;
        rdq(a, v);
        chk(32'(v), 32'(e), m);
    endtask

    // Reset values, an unmapped offset and the idle outputs.
    task automatic t_reset();
        rdchk(8'hbc, 8'h00, "ctrl reset");
        rdchk(8'hbd, 8'h00, "flags reset");
        rdchk(8'hbe, 8'h10, "enable reset");
        rdchk(8'hbf, 8'h00, "unmapped");
        chk(32'({use_default_addr, vref_oe}), 32'h3, "idle outputs");
    endtask

    // Enable, clock gate, detach and the read-only status bit.
    task automatic t_ctrl();
        wr(8'hbc, 8'h00);
        chk(32'({core_reset, xcvr_enable, core_clk_enable, clk48_enable}), 32'h8, "dn");
        wr(8'hbc, 8'h80);
        chk(32'({core_reset, xcvr_enable, core_clk_enable, clk48_enable}), 32'h7, "up");
        wr(8'hbc, 8'hc0);
        chk(32'(clk48_enable), 32'h0, "gated");
        wr(8'hbc, 8'h90);
        chk(32'({clk48_enable, vref_oe}), 32'h2, "detach");
        wr(8'hbc, 8'h8b);
        chk(32'({vref_oe, use_default_addr}), 32'h2, "attach addr");
        rdchk(8'hbc, 8'h83, "status read-only");
    endtask

    // A long SE0 clears configuration and address, then flags end of reset.
    task automatic t_bus_reset();
        line_se0 <= 1'b1;
        repeat (35) @(posedge pclk);
        line_se0 <= 1'b0;
        repeat (4) @(posedge pclk);
        chk(32'({use_default_addr, usb_irq}), 32'h3, "bus reset");
        rdchk(8'hbc, 8'h80, "cfg cleared");
        wr(8'hbd, 8'hff);
        rdchk(8'hbd, 8'h10, "eor kept");
        wr(8'hbd, 8'hef);
        rdchk(8'hbd, 8'h00, "eor cleared");
        chk(32'(usb_irq), 32'h0, "irq off");
        wr(8'hbe, 8'hff);
        rdchk(8'hbe, 8'h39, "enable reserved");
    endtask

    // Frame start is sticky, raises the interrupt when enabled and drops when masked.
    task automatic t_sof();
        wr(8'hbe, 8'h08);
        sof_pid_seen <= 1'b1;
        @(posedge pclk);
        sof_pid_seen <= 1'b0;
        rdchk(8'hbd, 8'h08, "sof");
        rdchk(8'hbd, 8'h08, "sof sticky");
        chk(32'(usb_irq), 32'h1, "sof irq");
        wr(8'hbe, 8'h00);
        chk(32'(usb_irq), 32'h0, "masked");
        wr(8'hbd, 8'h00);
        rdchk(8'hbd, 8'h00, "sof cleared");
        wr(8'hbe, 8'h21);
    endtask

    // Suspend on idle J, power-down service, wake from the bus and wake service.
    task automatic t_suspend();
        bus_j <= 1'b1;
        repeat (30) @(posedge pclk);
        rdchk(8'hbd, 8'h01, "suspend");
        chk(32'(usb_irq), 32'h1, "suspend irq");
        wr(8'hbc, 8'hc0);
        fw_cmd(32'h0008_0000);
        chk(32'({power_down, pad_low_power}), 32'h3, "low power");
        rdchk(8'hbd, 8'h00, "suspend cleared");
        bus_j <= 1'b0;
        repeat (6) @(posedge pclk);
        chk(32'({pad_low_power, usb_irq}), 32'h1, "bus wake");
        rdchk(8'hbd, 8'h20, "wake flag");
        fw_cmd(32'h0004_0000);
        rdchk(8'hbc, 8'h80, "clock back");
        rdchk(8'hbd, 8'h00, "wake cleared");
    endtask

    // Remote wake waits for running clocks, and its own K sets no wake flag.
    task automatic t_remote();
        int n;
        logic [7:0] v;
        wr(8'hbc, 8'h84);
        bus_j <= 1'b1;
        repeat (30) @(posedge pclk);
        wr(8'hbd, 8'h38);
        wr(8'hbc, 8'he4);
        rdchk(8'hbc, 8'hec, "resume status");
        chk(32'(resume_k_drive), 32'h0, "gated no K");
        wr(8'hbc, 8'ha4);
        n = 0;
        while (resume_k_drive !== 1'b1 && n < 100)
        begin
            @(posedge pclk);
            n++;
        end
        chk(32'(resume_k_drive), 32'h1, "K sent");
        repeat (14) @(posedge pclk);
        chk(32'(resume_k_drive), 32'h0, "K ended");
        bus_j <= 1'b0;
        rdchk(8'hbc, 8'ha4, "status cleared");
        rdq(8'hbd, v);
        chk(32'(v & 8'h20), 32'h0, "own resume");
        wr(8'hbc, 8'h00);
    endtask

    // Eight cycles of reset, then the scenarios in order.
    initial
    begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 32'h0000_0000;
        pwdata = 32'h0000_0000;
        line_se0 = 1'b0;
        bus_j = 1'b0;
        sof_pid_seen = 1'b0;
        err_count = 0;
        check_count = 0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset();
        t_ctrl();
        t_bus_reset();
        t_sof();
        t_suspend();
        t_remote();
        wrap_up();
    end
endmodule

// ==== bench/usbgc_asserts.sv ====
// Concurrent checks on the register port and the outputs of the USB global control block.
// Assumes one pclk domain, an active-low asynchronous presetn and a bus-reset count of 27.
`timescale 1ns/1ns
`include "usbgc_consts.svh"
module usbgc_asserts (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    input wire logic [7:0] sfr_rdata,
    input wire logic line_se0,
    input wire logic usb_irq,
    input wire logic core_reset,
    input wire logic xcvr_enable,
    input wire logic core_clk_enable,
    input wire logic clk48_enable,
    input wire logic vref_oe,
    input wire logic use_default_addr
);
    logic [5:0] se0_run_r;
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // Run length of SE0 at the pin; it saturates so that a long reset cannot wrap to zero.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            se0_run_r <= 6'h00;
        else if (!line_se0)
            se0_run_r <= 6'h00;
        else if (se0_run_r != 6'h3f)
            se0_run_r <= se0_run_r + 6'h01;
    end

    // Register writes are single strobes; the output checks are timed from them.
    sequence ctrl_wr;
        sfr_wr && sfr_addr == `USBGC_OFS_CTRL;
    endsequence
    sequence ien_wr;
        sfr_wr && sfr_addr == `USBGC_OFS_IEN;
    endsequence
    property p_rsvd;
        sfr_rd && sfr_addr inside {`USBGC_OFS_FLAGS, `USBGC_OFS_IEN}
            |=> (sfr_rdata & 8'hc6) == 8'h00;
    endproperty
    property p_disable;
        core_reset |-> !(xcvr_enable || core_clk_enable || clk48_enable);
    endproperty

    // The margin of seven cycles covers the pin synchronizer and the output flop.
    AST_DISABLE: assert property (p_disable)
        else $error("disabled controller has a clock or transceiver on");
    AST_EN_OFF: assert property (ctrl_wr ##0 !sfr_wdata[7] |-> ##[1:2] core_reset)
        else $error("clearing enable did not reset the controller");
    AST_CLKGATE: assert property (ctrl_wr ##0 sfr_wdata[6] |-> ##[1:2] !clk48_enable)
        else $error("clock gate bit did not stop the 48MHz clock");
    AST_DETACH_SET: assert property (ctrl_wr ##0 sfr_wdata[4] |-> ##[1:2] !vref_oe)
        else $error("detach did not float the pull-up output");
    AST_DETACH_CLR: assert property (ctrl_wr ##0 !sfr_wdata[4] |-> ##[1:2] vref_oe)
        else $error("pull-up output not driven with detach clear");
    AST_RSVD: assert property (p_rsvd)
        else $error("reserved bits read as one");
    AST_BUS_RESET: assert property (se0_run_r == 6'h22 |-> use_default_addr)
        else $error("long SE0 did not return to the default address");
    AST_IRQ_OFF: assert property (ien_wr ##0 sfr_wdata == 8'h00 |-> ##[1:2] !usb_irq)
        else $error("interrupt stays up with all enables clear");
endmodule

// ==== pkg/usbgc_consts.svh ====
// Constants for the USB global control block: register offsets, field positions, reset values
// and bus timing figures.
// Assumes a 10 MHz pclk; every count below is derived from the figures by expression.
`ifndef USBGC_CONSTS_SVH
`define USBGC_CONSTS_SVH

`define USBGC_OFS_CTRL 8'hbc
`define USBGC_OFS_FLAGS 8'hbd
`define USBGC_OFS_IEN 8'hbe

`define USBGC_B_EN 7
`define USBGC_B_CLKGATE 6
`define USBGC_B_SDRW 5
`define USBGC_B_DETACH 4
`define USBGC_B_UPSTREAM_RESUME_ACTIVE 3
`define USBGC_B_RWE 2
`define USBGC_B_CFG 1
`define USBGC_B_FADD 0

`define USBGC_B_WUP 5
`define USBGC_B_EOR 4
`define USBGC_B_SOF 3
`define USBGC_B_SUSP 0
`define USBGC_FLAG_MASK 8'h39
`define USBGC_IEN_RESET 8'h10
`define USBGC_ZERO8 8'h00

`define USBGC_CLK_MHZ 10
`define USBGC_FS_BITS 32
`define USBGC_FS_MBPS 12
`define USBGC_RST_CYC ((`USBGC_FS_BITS * `USBGC_CLK_MHZ + `USBGC_FS_MBPS - 1) / `USBGC_FS_MBPS)
`define USBGC_SUSP_MS 3
`define USBGC_SUSP_CYC (`USBGC_SUSP_MS * 1000 * `USBGC_CLK_MHZ)
`define USBGC_RWU_MS 5
`define USBGC_RWU_CYC (`USBGC_RWU_MS * 1000 * `USBGC_CLK_MHZ)
`define USBGC_RES_MS 10
`define USBGC_RES_CYC (`USBGC_RES_MS * 1000 * `USBGC_CLK_MHZ)

`define USBGC_APB_CMD 32'h0000_0000
`define USBGC_APB_STAT 32'h0000_0004
`define USBGC_CMD_WR 16
`define USBGC_CMD_RD 17
`define USBGC_CMD_WAKE 18
`define USBGC_CMD_PDN 19
`define USBGC_CLR_WUP 8'h19
`define USBGC_CLR_SUSP 8'h38
`endif

// ==== pkg/usbgc_if.sv ====
// Register port between the USB global control block and the firmware-side controller.
// Assumes both ends run on the same pclk; strobes last one cycle.
`timescale 1ns/1ns
interface usbgc_if;
    logic [7:0] sfr_addr;
    logic sfr_wr;
    logic sfr_rd;
    logic [7:0] sfr_wdata;
    logic [7:0] sfr_rdata;
    modport dev (input sfr_addr, input sfr_wr, input sfr_rd, input sfr_wdata, output sfr_rdata);
    modport fw (output sfr_addr, output sfr_wr, output sfr_rd, output sfr_wdata, input sfr_rdata);
endinterface

// ==== pkg/usbgc_pkg.sv ====
// Types shared by both ends of the USB global control block.
// Assumes the constants header is compiled alongside.
package usbgc_pkg;
    typedef logic [7:0] usbgc_byte_t;
    typedef enum logic [2:0] {
        FW_IDLE,
        FW_RD_WAIT,
        FW_WAKE_RD,
        FW_WAKE_RDW,
        FW_WAKE_CTRL,
        FW_WAKE_FLAG,
        FW_PDN_FLAG
    } usbgc_fw_e;
endpackage

// ==== src/usbgc_dev.sv ====
// USB device global control block: control, flag and enable registers with suspend,
// resume, bus reset and frame start tracking.
// Assumes line_se0 and line_j come from the transceiver pins; sof_pid_seen comes from
// the packet decoder on pclk as a one-cycle pulse.
//
// The byte-wide strobed register port of usbgc_if was chosen for this implementation.
`timescale 1ns/1ns
`include "usbgc_consts.svh"
module usbgc_dev #(
    parameter int unsigned RST_CYC = `USBGC_RST_CYC,
    parameter int unsigned SUSP_CYC = `USBGC_SUSP_CYC,
    parameter int unsigned RWU_CYC = `USBGC_RWU_CYC,
    parameter int unsigned RES_CYC = `USBGC_RES_CYC,
    parameter int unsigned CW = 17
) (
    input wire logic pclk,
    input wire logic presetn,
    usbgc_if.dev sfr,
    input wire logic line_se0,
    input wire logic line_j,
    input wire logic sof_pid_seen,
    output logic usb_irq,
    output logic core_reset,
    output logic xcvr_enable,
    output logic core_clk_enable,
    output logic clk48_enable,
    output logic vref_oe,
    output logic resume_k_drive,
    output logic pad_low_power,
    output logic use_default_addr
);
    import usbgc_pkg::*;

    // Counters share one width; refuse counts that would misorder, or that would not fit except RST_CYC, whose fit is unchecked.
    if (CW > 31 || RST_CYC < 1 || SUSP_CYC < 2 || RWU_CYC < SUSP_CYC
        || RES_CYC < 1 || RWU_CYC >= (1 << CW) || RES_CYC >= (1 << CW))
    begin
        $error("usbgc_dev: timing parameters do not fit the counters");
    end

    function automatic logic hit(input usbgc_byte_t a, input usbgc_byte_t ofs);
        hit = (a == ofs);
    endfunction

    usbgc_byte_t ctrl_r, flags_r, ien_r, flags_nxt, rdata_r, rdata_nxt;
    logic se0_m_r, se0_s_r, j_m_r, j_s_r;
    logic [CW-1:0] se0_cnt_r, idle_cnt_r, res_cnt_r;
    logic in_rst_r, suspended_r, rwu_done_r;

    // Address decode and derived conditions are plain wires.
    wire sel_ctrl = hit(sfr.sfr_addr, `USBGC_OFS_CTRL);
    wire sel_flags = hit(sfr.sfr_addr, `USBGC_OFS_FLAGS);
    wire sel_ien = hit(sfr.sfr_addr, `USBGC_OFS_IEN);
    wire wr_ctrl = sfr.sfr_wr & sel_ctrl;
    wire wr_flags = sfr.sfr_wr & sel_flags;
    wire en = ctrl_r[`USBGC_B_EN];
    wire clocks_run = en & ~ctrl_r[`USBGC_B_CLKGATE];
    wire bus_rst = en & se0_s_r & (se0_cnt_r == CW'(RST_CYC));
    wire eor_evt = in_rst_r & ~se0_s_r;
    wire susp_evt = clocks_run & j_s_r & (idle_cnt_r == CW'(SUSP_CYC - 1));
    wire wake_evt = suspended_r & ~j_s_r & ~ctrl_r[`USBGC_B_UPSTREAM_RESUME_ACTIVE] & ~resume_k_drive;
    wire res_start = ctrl_r[`USBGC_B_UPSTREAM_RESUME_ACTIVE] & ~resume_k_drive & clocks_run
        & (idle_cnt_r == CW'(RWU_CYC));
    wire res_end = resume_k_drive & (res_cnt_r == CW'(RES_CYC - 1));
    // The end of a resume must beat the still-set send bit, or the status would stick.
    wire upstream_resume_active_set = ctrl_r[`USBGC_B_SDRW] & ctrl_r[`USBGC_B_RWE] & ~rwu_done_r
        & ~res_end;
    wire susp_clr_wr = wr_flags & ~sfr.sfr_wdata[`USBGC_B_SUSP] & flags_r[`USBGC_B_SUSP];
    wire [7:0] flag_set = {2'b00, wake_evt, eor_evt, en & sof_pid_seen, 2'b00, susp_evt};

    // Software writes zero to clear a flag; an event in the same cycle still sets it.
    assign flags_nxt = ((wr_flags ? (flags_r & sfr.sfr_wdata) : flags_r) | flag_set)
        & `USBGC_FLAG_MASK;
    assign rdata_nxt = sel_ctrl ? ctrl_r : sel_flags ? flags_r : sel_ien ? ien_r
        : `USBGC_ZERO8;
    assign sfr.sfr_rdata = rdata_r;

    // Bus lines come from pins, so each passes two flip-flops first.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            se0_m_r <= 1'b0;
            se0_s_r <= 1'b0;
            j_m_r <= 1'b1;
            j_s_r <= 1'b1;
        end
        else
        begin
            se0_m_r <= line_se0;
            se0_s_r <= se0_m_r;
            j_m_r <= line_j;
            j_s_r <= j_m_r;
        end
    end

    // Line timers: SE0 length for bus reset, idle J length for suspend and remote wakeup.
    // The idle timer keeps running with the 48MHz clock gated so suspend time accumulates.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            se0_cnt_r <= '0;
            idle_cnt_r <= '0;
            in_rst_r <= 1'b0;
        end
        else
        begin
            if (!en || !se0_s_r)
                se0_cnt_r <= '0;
            else if (se0_cnt_r != CW'(RST_CYC))
                se0_cnt_r <= se0_cnt_r + 1'b1;
            if (!en || !j_s_r || se0_s_r)
                idle_cnt_r <= '0;
            else if (idle_cnt_r != CW'(RWU_CYC))
                idle_cnt_r <= idle_cnt_r + 1'b1;
            in_rst_r <= bus_rst | (in_rst_r & se0_s_r);
        end
    end

    // Suspend state, pad low-power request and upstream resume sequencing.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            suspended_r <= 1'b0;
            pad_low_power <= 1'b0;
            resume_k_drive <= 1'b0;
            res_cnt_r <= '0;
            rwu_done_r <= 1'b0;
        end
        else
        begin
            suspended_r <= en & ~bus_rst & ~wake_evt & ~res_end & (suspended_r | susp_evt);
            if (wake_evt || res_start || !en)
                pad_low_power <= 1'b0;
            else if (susp_clr_wr && suspended_r)
                pad_low_power <= 1'b1;
            resume_k_drive <= en & (res_start | (resume_k_drive & ~res_end));
            res_cnt_r <= resume_k_drive ? res_cnt_r + 1'b1 : '0;
            // One resume per request: software must clear the send bit to ask again.
            rwu_done_r <= ctrl_r[`USBGC_B_SDRW] & (rwu_done_r | res_end);
        end
    end

    // Register file; hardware clears on bus reset take priority over firmware writes.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_r <= `USBGC_ZERO8;
            flags_r <= `USBGC_ZERO8;
            ien_r <= `USBGC_IEN_RESET;
            rdata_r <= `USBGC_ZERO8;
        end
        else
        begin
            if (wr_ctrl)
                ctrl_r <= {sfr.sfr_wdata[7:4], ctrl_r[`USBGC_B_UPSTREAM_RESUME_ACTIVE], sfr.sfr_wdata[2:0]};
            if (upstream_resume_active_set)
                ctrl_r[`USBGC_B_UPSTREAM_RESUME_ACTIVE] <= 1'b1;
            else if (res_end || !ctrl_r[`USBGC_B_RWE])
                ctrl_r[`USBGC_B_UPSTREAM_RESUME_ACTIVE] <= 1'b0;
            if (bus_rst)
            begin
                ctrl_r[`USBGC_B_CFG] <= 1'b0;
                ctrl_r[`USBGC_B_FADD] <= 1'b0;
            end
            flags_r <= flags_nxt;
            if (sfr.sfr_wr && sel_ien)
                ien_r <= sfr.sfr_wdata & `USBGC_FLAG_MASK;
            if (sfr.sfr_rd)
                rdata_r <= rdata_nxt;
        end
    end

    // Pin-facing outputs are registered copies of the control state.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            usb_irq <= 1'b0;
            core_reset <= 1'b1;
            xcvr_enable <= 1'b0;
            core_clk_enable <= 1'b0;
            clk48_enable <= 1'b0;
            vref_oe <= 1'b1;
            use_default_addr <= 1'b1;
        end
        else
        begin
            usb_irq <= |(flags_nxt & ien_r);
            core_reset <= ~en;
            xcvr_enable <= en;
            core_clk_enable <= en;
            clk48_enable <= clocks_run;
            vref_oe <= ~ctrl_r[`USBGC_B_DETACH];
            use_default_addr <= ~ctrl_r[`USBGC_B_FADD];
        end
    end
endmodule

// ==== src/usbgc_fw.sv ====
// Firmware-side controller: takes orders over APB and performs register accesses on the
// USB global control block, including the wake-up and power-down service sequences.
// Assumes a zero-wait APB master on pclk and the block's one-cycle read latency.
`timescale 1ns/1ns
`include "usbgc_consts.svh"
module usbgc_fw (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic power_down,
    usbgc_if.fw sfr
);
    import usbgc_pkg::*;

    usbgc_fw_e st_r;
    usbgc_byte_t addr_r, wdata_r, rd_r;
    logic wr_r, rd_str_r;

    wire setup = psel & ~penable;
    wire acc_wr = psel & penable & pwrite;
    wire cmd_wr = acc_wr & (paddr == `USBGC_APB_CMD) & (st_r == FW_IDLE);
    wire busy = (st_r != FW_IDLE);
    wire [31:0] stat_word = {15'h0000, power_down, rd_r, 7'h00, busy};

    assign sfr.sfr_addr = addr_r;
    assign sfr.sfr_wdata = wdata_r;
    assign sfr.sfr_wr = wr_r;
    assign sfr.sfr_rd = rd_str_r;

    // APB answers with no wait state; read data is captured in the setup cycle.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready <= 1'b1;
            pslverr <= 1'b0;
            if (setup)
                prdata <= (paddr == `USBGC_APB_STAT) ? stat_word : 32'h0000_0000;
        end
    end

    // Sequencer: generic access, wake service, power-down service.
    // Commands arriving while busy are dropped; software polls the busy bit.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_r <= FW_IDLE;
            addr_r <= 8'h00;
            wdata_r <= 8'h00;
            rd_r <= 8'h00;
            wr_r <= 1'b0;
            rd_str_r <= 1'b0;
            power_down <= 1'b0;
        end
        else
        begin
            wr_r <= 1'b0;
            rd_str_r <= 1'b0;
            unique case (st_r)
                FW_IDLE:
                begin
                    if (cmd_wr)
                    begin
                        addr_r <= pwdata[7:0];
                        wdata_r <= pwdata[15:8];
                        power_down <= 1'b0;
                        // Remote wakeup enable, configured and address enable are set
                        // here only as software orders them.
                        if (pwdata[`USBGC_CMD_WAKE])
                        begin
                            addr_r <= `USBGC_OFS_CTRL;
                            rd_str_r <= 1'b1;
                            st_r <= FW_WAKE_RD;
                        end
                        else if (pwdata[`USBGC_CMD_PDN])
                        begin
                            addr_r <= `USBGC_OFS_FLAGS;
                            wdata_r <= `USBGC_CLR_SUSP;
                            wr_r <= 1'b1;
                            st_r <= FW_PDN_FLAG;
                        end
                        else if (pwdata[`USBGC_CMD_WR])
                            wr_r <= 1'b1;
                        else if (pwdata[`USBGC_CMD_RD])
                        begin
                            rd_str_r <= 1'b1;
                            st_r <= FW_RD_WAIT;
                        end
                    end
                end
                FW_RD_WAIT:
                begin
                    // Read data stands only after the strobe is sampled, so wait a cycle.
                    if (!rd_str_r)
                        st_r <= FW_IDLE;
                end
                FW_WAKE_RD:
                    st_r <= FW_WAKE_RDW;
                FW_WAKE_RDW:
                begin
                    // Clocks are restored before the wakeup flag is touched.
                    wdata_r <= sfr.sfr_rdata & ~(8'h01 << `USBGC_B_CLKGATE);
                    wr_r <= 1'b1;
                    st_r <= FW_WAKE_CTRL;
                end
                FW_WAKE_CTRL:
                begin
                    addr_r <= `USBGC_OFS_FLAGS;
                    wdata_r <= `USBGC_CLR_WUP;
                    wr_r <= 1'b1;
                    st_r <= FW_WAKE_FLAG;
                end
                FW_WAKE_FLAG:
                    st_r <= FW_IDLE;
                FW_PDN_FLAG:
                begin
                    power_down <= 1'b1;
                    st_r <= FW_IDLE;
                end
            endcase
            if (st_r == FW_RD_WAIT && !rd_str_r)
                rd_r <= sfr.sfr_rdata;
        end
    end
endmodule
